// ==== rtl/hpu_pkg.sv ====
`default_nettype none

package hpu_pkg;

    // Bus and pixel geometry
    localparam int BUS_W      = 24;
    localparam int COMP_W     = 8;
    localparam int PIX_W      = 24;
    localparam int FIFO_DEPTH = 32;

    // Bus width and packing codes on bus_mode
    localparam logic [2:0] MODE_24    = 3'h0;
    localparam logic [2:0] MODE_18    = 3'h1;
    localparam logic [2:0] MODE_16    = 3'h2;
    localparam logic [2:0] MODE_16P   = 3'h3;
    localparam logic [2:0] MODE_12    = 3'h4;
    localparam logic [2:0] MODE_9     = 3'h5;
    localparam logic [2:0] MODE_8     = 3'h6;

    // Field positions (low bit of each field)
    localparam int F24_R_LSB  = 16;
    localparam int F24_G_LSB  = 8;
    localparam int F18_R_LSB  = 12;
    localparam int F18_G_LSB  = 6;
    localparam int F565_R_LSB = 11;
    localparam int F565_G_LSB = 5;
    localparam int F16P_H_LSB = 8;
    localparam int F12_R_LSB  = 4;
    localparam int F12_G_LSB  = 8;
    localparam int F9_R_LSB   = 3;
    localparam int F9_G_LSB   = 6;

    // Position within a multi-cycle group
    typedef enum logic [2:0] {
        HPU_PH0 = 3'b001,
        HPU_PH1 = 3'b010,
        HPU_PH2 = 3'b100
    } hpu_phase_t;

endpackage

`default_nettype wire

// ==== rtl/hpu_unpacker.sv ====
// Functional notes
// - Widths 8, 9, 12, 16, 18 and 24 bits all accepted on the host bus.
// - 24-bit: one write, red 23..16, green 15..8, blue 7..0.
// - 18-bit: one write, red 17..12, green 11..6, blue 5..0.
// - 16-bit 565: one write, red 15..11, green 10..5, blue 4..0.
// - Packed 16-bit: three writes carry two 888 pixels, high byte first.
// - 9-bit: two writes, R6 and G high three, then G low three and B6.
// - 8-bit: three writes, red then green then blue on bits 7..0.
`timescale 1ns/1ns
`default_nettype none

module hpu_fifo #(
    parameter int W     = 24,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    ov;
        logic [W-1:0]            od;
    } hpu_fifo_st_t;

    hpu_fifo_st_t st_r;
    hpu_fifo_st_t st_nxt;
    logic         push;
    logic         load;

    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = st_r.ov;
    assign out_data  = st_r.od;

    // Output word is a register so the drain side sees no memory read path
    always_comb begin
        st_nxt = st_r;
        push   = in_valid && in_ready;
        load   = (st_r.cnt != '0) && (!st_r.ov || out_ready);
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + AW'(1);
        end
        if (load) begin
            st_nxt.od = st_r.mem[st_r.rp];
            st_nxt.ov = 1'b1;
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + AW'(1);
        end else if (out_ready) begin
            st_nxt.ov = 1'b0;
        end
        if (push && !load) begin
            st_nxt.cnt = st_r.cnt + (AW+1)'(1);
        end else if (load && !push) begin
            st_nxt.cnt = st_r.cnt - (AW+1)'(1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

module hpu_unpacker #(
    parameter int FIFO_DEPTH = hpu_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         rstn,
    // Host parallel bus pins
    input  wire logic                         host_cs_n,
    input  wire logic                         host_wr_n,
    input  wire logic                         host_dc,
    input  wire logic [hpu_pkg::BUS_W-1:0]    host_data,
    // Configuration from local logic
    input  wire logic [2:0]                   bus_mode,
    // Pixel stream out
    output logic                              pix_valid,
    output logic [hpu_pkg::COMP_W-1:0]        pix_red,
    output logic [hpu_pkg::COMP_W-1:0]        pix_grn,
    output logic [hpu_pkg::COMP_W-1:0]        pix_blu,
    input  wire logic                         pix_ready,
    // Status
    output logic                              host_busy,
    output logic                              pix_drop
);
    localparam int CW = hpu_pkg::COMP_W;

    typedef struct packed {
        logic                      cs_s1;
        logic                      cs_s2;
        logic                      wr_s1;
        logic                      wr_s2;
        logic                      wr_s3;
        logic                      dc_s1;
        logic                      dc_s2;
        logic [hpu_pkg::BUS_W-1:0] d_s1;
        logic [hpu_pkg::BUS_W-1:0] d_s2;
        logic [2:0]                mode;
        hpu_pkg::hpu_phase_t       phase;
        logic [CW-1:0]             r_hold;
        logic [CW-1:0]             g_hold;
        logic                      push_v;
        logic [hpu_pkg::PIX_W-1:0] push_d;
        logic                      busy;
        logic                      drop;
    } hpu_st_t;

    hpu_st_t                   st_r;
    hpu_st_t                   st_nxt;
    logic                      take;
    logic                      fifo_ready;
    logic [hpu_pkg::PIX_W-1:0] fifo_data;
    logic [hpu_pkg::BUS_W-1:0] d;

    // Widen short components by repeating their top bits
    // Full scale stays full scale: all-ones widens to all-ones
    function automatic logic [CW-1:0] exp5(input logic [4:0] v);
        exp5 = {v, v[4:2]};
    endfunction

    function automatic logic [CW-1:0] exp6(input logic [5:0] v);
        exp6 = {v, v[5:4]};
    endfunction

    always_comb begin
        st_nxt       = st_r;
        d            = st_r.d_s2;
        // Two flops per pin; the strobe gets a third to see its rising edge
        st_nxt.cs_s1 = host_cs_n;
        st_nxt.cs_s2 = st_r.cs_s1;
        st_nxt.wr_s1 = host_wr_n;
        st_nxt.wr_s2 = st_r.wr_s1;
        st_nxt.wr_s3 = st_r.wr_s2;
        st_nxt.dc_s1 = host_dc;
        st_nxt.dc_s2 = st_r.dc_s1;
        st_nxt.d_s1  = host_data;
        st_nxt.d_s2  = st_r.d_s1;
        // Data write ends on the rising write strobe, bus is stable then
        // Takes are two or more cycles apart, so push_v never lasts two cycles
        take          = st_r.wr_s2 && !st_r.wr_s3 && !st_r.cs_s2 && st_r.dc_s2;
        st_nxt.push_v = 1'b0;
        st_nxt.drop   = st_r.push_v && !fifo_ready;
        st_nxt.busy   = !fifo_ready;
        // bus_mode comes from logic on this clock, so it needs no synchroniser
        if (bus_mode != st_r.mode) begin
            // A write landing on the change is discarded, not half-assembled
            st_nxt.mode  = bus_mode;
            st_nxt.phase = hpu_pkg::HPU_PH0;
        end else if (take) begin
            case (st_r.mode)
                hpu_pkg::MODE_24: begin
                    st_nxt.push_v = 1'b1;
                    st_nxt.push_d = {d[hpu_pkg::F24_R_LSB +: CW],
                                     d[hpu_pkg::F24_G_LSB +: CW], d[CW-1:0]};
                end
                hpu_pkg::MODE_18: begin
                    st_nxt.push_v = 1'b1;
                    st_nxt.push_d = {exp6(d[hpu_pkg::F18_R_LSB +: 6]),
                                     exp6(d[hpu_pkg::F18_G_LSB +: 6]),
                                     exp6(d[5:0])};
                end
                hpu_pkg::MODE_16: begin
                    st_nxt.push_v = 1'b1;
                    st_nxt.push_d = {exp5(d[hpu_pkg::F565_R_LSB +: 5]),
                                     exp6(d[hpu_pkg::F565_G_LSB +: 6]),
                                     exp5(d[4:0])};
                end
                hpu_pkg::MODE_16P: begin
                    case (st_r.phase)
                        hpu_pkg::HPU_PH0: begin
                            st_nxt.r_hold = d[hpu_pkg::F16P_H_LSB +: CW];
                            st_nxt.g_hold = d[CW-1:0];
                            st_nxt.phase  = hpu_pkg::HPU_PH1;
                        end
                        hpu_pkg::HPU_PH1: begin
                            st_nxt.push_v = 1'b1;
                            st_nxt.push_d = {st_r.r_hold, st_r.g_hold,
                                             d[hpu_pkg::F16P_H_LSB +: CW]};
                            // Second pixel's red waits in the red slot
                            st_nxt.r_hold = d[CW-1:0];
                            st_nxt.phase  = hpu_pkg::HPU_PH2;
                        end
                        hpu_pkg::HPU_PH2: begin
                            st_nxt.push_v = 1'b1;
                            st_nxt.push_d = {st_r.r_hold,
                                             d[hpu_pkg::F16P_H_LSB +: CW], d[CW-1:0]};
                            st_nxt.phase  = hpu_pkg::HPU_PH0;
                        end
                        default: begin
                            st_nxt.phase = hpu_pkg::HPU_PH0;
                        end
                    endcase
                end
                hpu_pkg::MODE_12: begin
                    if (st_r.phase == hpu_pkg::HPU_PH0) begin
                        st_nxt.r_hold = d[hpu_pkg::F12_R_LSB +: CW];
                        st_nxt.g_hold = {d[3:0], 4'h0};
                        st_nxt.phase  = hpu_pkg::HPU_PH1;
                    end else begin
                        st_nxt.push_v = 1'b1;
                        st_nxt.push_d = {st_r.r_hold, st_r.g_hold[7:4],
                                         d[hpu_pkg::F12_G_LSB +: 4], d[CW-1:0]};
                        st_nxt.phase  = hpu_pkg::HPU_PH0;
                    end
                end
                hpu_pkg::MODE_9: begin
                    if (st_r.phase == hpu_pkg::HPU_PH0) begin
                        st_nxt.r_hold = exp6(d[hpu_pkg::F9_R_LSB +: 6]);
                        st_nxt.g_hold = {5'h00, d[2:0]};
                        st_nxt.phase  = hpu_pkg::HPU_PH1;
                    end else begin
                        st_nxt.push_v = 1'b1;
                        st_nxt.push_d = {st_r.r_hold,
                                         exp6({st_r.g_hold[2:0], d[hpu_pkg::F9_G_LSB +: 3]}),
                                         exp6(d[5:0])};
                        st_nxt.phase  = hpu_pkg::HPU_PH0;
                    end
                end
                hpu_pkg::MODE_8: begin
                    case (st_r.phase)
                        hpu_pkg::HPU_PH0: begin
                            st_nxt.r_hold = d[CW-1:0];
                            st_nxt.phase  = hpu_pkg::HPU_PH1;
                        end
                        hpu_pkg::HPU_PH1: begin
                            st_nxt.g_hold = d[CW-1:0];
                            st_nxt.phase  = hpu_pkg::HPU_PH2;
                        end
                        hpu_pkg::HPU_PH2: begin
                            st_nxt.push_v = 1'b1;
                            st_nxt.push_d = {st_r.r_hold, st_r.g_hold, d[CW-1:0]};
                            st_nxt.phase  = hpu_pkg::HPU_PH0;
                        end
                        default: begin
                            st_nxt.phase = hpu_pkg::HPU_PH0;
                        end
                    endcase
                end
                default: begin
                    st_nxt.phase = hpu_pkg::HPU_PH0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            st_r       <= '0;
            st_r.cs_s1 <= 1'b1;
            st_r.cs_s2 <= 1'b1;
            st_r.wr_s1 <= 1'b1;
            st_r.wr_s2 <= 1'b1;
            st_r.wr_s3 <= 1'b1;
            st_r.mode  <= hpu_pkg::MODE_24;
            st_r.phase <= hpu_pkg::HPU_PH0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // No wait pin on the host bus: a full FIFO loses the pixel and says so
    // Capacity is the stored words plus the word on show at the output
    hpu_fifo #(
        .W     (hpu_pkg::PIX_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rstn      (rstn),
        .in_valid  (st_r.push_v),
        .in_data   (st_r.push_d),
        .in_ready  (fifo_ready),
        .out_valid (pix_valid),
        .out_data  (fifo_data),
        .out_ready (pix_ready)
    );

    assign pix_red   = fifo_data[2*CW +: CW];
    assign pix_grn   = fifo_data[CW +: CW];
    assign pix_blu   = fifo_data[CW-1:0];
    assign host_busy = st_r.busy;
    assign pix_drop  = st_r.drop;
endmodule

`default_nettype wire

// ==== test/hpu_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpu_host_model (
    input  wire logic   sys_clk,
    output logic        host_cs_n,
    output logic        host_wr_n,
    output logic        host_dc,
    output logic [23:0] host_data
);
    initial begin
        host_cs_n = 1'b1;
        host_wr_n = 1'b1;
        host_dc   = 1'b1;
        host_data = 24'h000000;
    end
    // Strobe low and high three cycles each, so the synchroniser sees both
    task automatic write(input logic [23:0] d, input logic dc, input logic cs_n);
        @(posedge sys_clk);
        host_cs_n <= cs_n;
        host_dc   <= dc;
        host_data <= d;
        host_wr_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        host_wr_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        host_cs_n <= 1'b1;
        // Released bus shows the inverse, not a stale copy
        host_data <= ~d;
    endtask
endmodule
`default_nettype wire

// ==== test/hpu_unpacker_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpu_unpacker_props (
    // Clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rstn,
    // Host pins
    input wire logic                      host_cs_n,
    input wire logic                      host_wr_n,
    input wire logic                      host_dc,
    input wire logic [hpu_pkg::BUS_W-1:0] host_data,
    input wire logic [2:0]                bus_mode,
    // Pixel side
    input wire logic                      pix_valid,
    input wire logic [7:0]                pix_red,
    input wire logic [7:0]                pix_grn,
    input wire logic [7:0]                pix_blu,
    input wire logic                      pix_ready,
    input wire logic                      host_busy,
    input wire logic                      pix_drop
);
    logic [23:0] cap_r;
    wire  [23:0] pix = {pix_red, pix_grn, pix_blu};
    // Held past the strobe edge, so the pipeline can be compared late
    always_ff @(posedge sys_clk) if ($rose(host_wr_n)) cap_r <= host_data;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_take(logic [2:0] m);
        $rose(host_wr_n) && !host_cs_n && host_dc && bus_mode == m && !pix_valid;
    endsequence
    property p_rst;
        disable iff (1'b0) !rstn |=> !pix_valid && !host_busy && !pix_drop;
    endproperty
    property p_hold;   pix_valid && !pix_ready |=> pix_valid;              endproperty
    property p_stable; pix_valid && !pix_ready |=> $stable(pix);           endproperty
    property p_drop;   pix_drop |=> !pix_drop;                             endproperty
    property p_busy;   host_busy |-> pix_valid;                            endproperty
    property p_dbusy;  pix_drop |-> host_busy || $past(host_busy);         endproperty
    property p_d24;    s_take(hpu_pkg::MODE_24) |-> ##[2:6] pix_valid && pix == cap_r;
    endproperty
    property p_d565;
        s_take(hpu_pkg::MODE_16) |-> ##[2:6] pix_valid && pix == {cap_r[15:11],
            cap_r[15:13], cap_r[10:5], cap_r[10:9], cap_r[4:0], cap_r[4:2]};
    endproperty
    a_rst:    assert property (p_rst)    else $error("outputs not cleared by reset");
    a_hold:   assert property (p_hold)   else $error("pixel withdrawn before accept");
    a_stable: assert property (p_stable) else $error("pixel changed while stalled");
    a_drop:   assert property (p_drop)   else $error("drop pulse too long");
    a_busy:   assert property (p_busy)   else $error("busy with no pixel out");
    a_dbusy:  assert property (p_dbusy)  else $error("drop while not full");
    a_d24:    assert property (p_d24)    else $error("24-bit pixel wrong");
    a_d565:   assert property (p_d565)   else $error("565 pixel wrong");
endmodule
bind hpu_unpacker hpu_unpacker_props u_props (.sys_clk(sys_clk), .rstn(rstn),
    .host_cs_n(host_cs_n), .host_wr_n(host_wr_n), .host_dc(host_dc), .host_data(host_data),
    .bus_mode(bus_mode), .pix_valid(pix_valid), .pix_red(pix_red), .pix_grn(pix_grn),
    .pix_blu(pix_blu), .pix_ready(pix_ready), .host_busy(host_busy), .pix_drop(pix_drop));
`default_nettype wire

// ==== test/hpu_unpacker_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module hpu_unpacker_tb;
    logic        sys_clk, rstn, pix_ready, ready_en, host_cs_n, host_wr_n, host_dc;
    logic        pix_valid, host_busy, pix_drop;
    logic [23:0] host_data;
    logic [2:0]  bus_mode;
    logic [7:0]  pix_red, pix_grn, pix_blu;
    logic [23:0] exp_q[$];
    logic [23:0] exp_w;
    int          failures, samples_checked, drops;
    initial sys_clk = 1'b0;
    always #25 sys_clk = ~sys_clk;
    hpu_unpacker dut (.sys_clk(sys_clk), .rstn(rstn), .host_cs_n(host_cs_n),
        .host_wr_n(host_wr_n), .host_dc(host_dc), .host_data(host_data), .bus_mode(bus_mode),
        .pix_valid(pix_valid), .pix_red(pix_red), .pix_grn(pix_grn), .pix_blu(pix_blu),
        .pix_ready(pix_ready), .host_busy(host_busy), .pix_drop(pix_drop));
    hpu_host_model host (.sys_clk(sys_clk), .host_cs_n(host_cs_n), .host_wr_n(host_wr_n),
        .host_dc(host_dc), .host_data(host_data));
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("Checked %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) pix_ready <= ready_en ? 1'($urandom_range(1)) : 1'b0;
    always @(posedge sys_clk) if (rstn && pix_drop === 1'b1) drops++;
    always @(posedge sys_clk) if (rstn && pix_valid === 1'b1 && pix_ready === 1'b1) begin
        // Unexpected pixel is held against its own inverse so it always counts
        exp_w = exp_q.size() > 0 ? exp_q.pop_front() : ~{pix_red, pix_grn, pix_blu};
        check("pixel", {pix_red, pix_grn, pix_blu}, exp_w);
    end
    function automatic logic [7:0] w5(input logic [4:0] c); return {c, c[4:2]}; endfunction
    function automatic logic [7:0] w6(input logic [5:0] c); return {c, c[5:4]}; endfunction
    task automatic wr(input logic [23:0] d); host.write(d, 1'b1, 1'b0); endtask
    task automatic set_mode(input logic [2:0] m);
        repeat (2) @(posedge sys_clk);
        bus_mode <= m;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic drain(input string name);
        for (int i = 0; i < 3000 && exp_q.size() > 0; i++) @(posedge sys_clk);
        repeat (8) @(posedge sys_clk);
        if (exp_q.size() > 0) begin
            failures++;
            close_out();
        end else begin
            $display("Test %s done", name);
        end
    endtask
    task automatic send(input logic [2:0] m, input logic [23:0] p);
        logic [7:0]  r, g, b;
        logic [23:0] j;
        {r, g, b} = p;
        j = 24'($urandom);
        case (m)
            hpu_pkg::MODE_24: begin exp_q.push_back(p); wr(p); end
            hpu_pkg::MODE_18: begin
                exp_q.push_back({w6(r[7:2]), w6(g[7:2]), w6(b[7:2])});
                wr({j[5:0], r[7:2], g[7:2], b[7:2]});
            end
            hpu_pkg::MODE_16: begin
                exp_q.push_back({w5(r[7:3]), w6(g[7:2]), w5(b[7:3])});
                wr({j[7:0], r[7:3], g[7:2], b[7:3]});
            end
            hpu_pkg::MODE_12: begin
                exp_q.push_back(p);
                wr({j[11:0], r, g[7:4]});
                wr({j[11:0], g[3:0], b});
            end
            hpu_pkg::MODE_9: begin
                exp_q.push_back({w6(r[7:2]), w6(g[7:2]), w6(b[7:2])});
                wr({j[14:0], r[7:2], g[7:5]});
                wr({j[14:0], g[4:2], b[7:2]});
            end
            default: begin
                exp_q.push_back(p);
                wr({j[15:0], r});
                wr({j[15:0], g});
                wr({j[15:0], b});
            end
        endcase
    endtask
    task automatic send_pair(input logic [23:0] p1, input logic [23:0] p2);
        logic [7:0] j;
        j = 8'($urandom);
        exp_q.push_back(p1);
        exp_q.push_back(p2);
        wr({j, p1[23:8]});
        wr({j, p1[7:0], p2[23:16]});
        wr({j, p2[15:0]});
    endtask
    initial begin
        rstn = 1'b0;
        ready_en = 1'b0;
        pix_ready = 1'b0;
        bus_mode = hpu_pkg::MODE_24;
        failures = 0;
        samples_checked = 0;
        drops = 0;
        void'($urandom(32'h2347));
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        ready_en <= 1'b1;
        for (int m = 0; m < 7; m++) if (m != 3) begin
            set_mode(3'(m));
            send(3'(m), 24'hFFFFFF);
            repeat (4) send(3'(m), 24'($urandom));
        end
        set_mode(hpu_pkg::MODE_16P);
        repeat (3) send_pair(24'($urandom), 24'($urandom));
        drain("formats");
        // Command, unselected and mode 7 writes must leave no pixel
        set_mode(hpu_pkg::MODE_24);
        host.write(24'h123456, 1'b0, 1'b0);
        host.write(24'h654321, 1'b1, 1'b1);
        set_mode(3'h7);
        wr(24'hABCDEF);
        // Partial group dropped by mode change, next group starts clean
        set_mode(hpu_pkg::MODE_8);
        wr(24'h000011);
        set_mode(hpu_pkg::MODE_24);
        send(hpu_pkg::MODE_24, 24'h0A0B0C);
        set_mode(hpu_pkg::MODE_8);
        send(hpu_pkg::MODE_8, 24'h102030);
        drain("refusals");
        set_mode(hpu_pkg::MODE_24);
        ready_en <= 1'b0;
        repeat (4) @(posedge sys_clk);
        drops = 0;
        // 32 stored words plus the one on show, then two that must be lost
        for (int i = 0; i < 35; i++)
            if (i < 33) send(hpu_pkg::MODE_24, 24'($urandom));
            else wr(24'($urandom));
        repeat (6) @(posedge sys_clk);
        check("host_busy", 24'(host_busy), 24'h000001);
        check("drop count", 24'(drops), 24'h000002);
        ready_en <= 1'b1;
        drain("overflow");
        check("pix_valid idle", 24'(pix_valid), 24'h000000);
        close_out();
    end
endmodule
`default_nettype wire
